// File: design/pgp_pkg.sv
package pgp_pkg;
   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [11:0] ADDR_FUNC_SEL = 12'h000;
   localparam logic [11:0] ADDR_DIR      = 12'h004;
   localparam logic [11:0] ADDR_DATA     = 12'h008;
   localparam logic [11:0] ADDR_PULLUP   = 12'h00C;
   // ****************************************
   // field positions and masks
   // ****************************************
   localparam int          FS_PIN7_BIT   = 7;
   localparam int          FS_PIN4_BIT   = 4;
   localparam int          FS_TX2_BIT    = 3;
   localparam int          FS_RSVD2_BIT  = 2;
   localparam int          FS_TX_BIT     = 1;
   localparam int          RSVD_PIN_BIT  = 3;
   localparam logic [7:0]  FS_MASK       = 8'h9E;
   localparam logic [7:0]  PORT_MASK     = 8'hF7;
   localparam logic [7:0]  RSVD_ONE      = 8'h08;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0]  FS_RESET      = 8'h00;
   localparam logic [7:0]  DIR_RESET     = 8'h00;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [7:0]  PULLUP_RESET  = 8'h00;
endpackage

// File: design/pgp_port1.sv
// Notes on behaviour
// - after reset every pin is an input, nothing driven
// - select bit 7 routes pin 7 to interrupt 3 and timer trigger
// - select bit 4 routes pin 4 to interrupt 0
// - select bit 3 makes other port pin 2 the second serial transmit
// - select bit 1 makes serial port pin 2 the serial transmit
// - select bits 6, 5 and 0 read zero, hold nothing
// - direction bit 1 makes a general pin an output, 0 an input
// - bit 3 reserved; reads as 1 in data and pull-up
// - data register value drives general output pins
// - data read of an output bit returns stored value
// - data read of an input bit returns synchronised pin level
// - pull-up bit enables pull-up only while direction bit is 0
// - peripheral function overrides the direction bit; code masks pin_oe only on pins 7 and 4, data read still uses direction
//
// Decided for this implementation: register access over APB and the register addresses.
module pgp_port1 (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // port pins
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe,
   output logic      [7:0]  pin_pullup,
   // peripheral routing
   output logic             ext_interrupt_3_input,
   output logic             timer_trigger_input,
   output logic             ext_interrupt_0_input,
   output logic             second_serial_tx_select,
   output logic             serial_tx_select
);

   // ****************************************
   // pin synchroniser
   // ****************************************
   logic [7:0] sync1_q, sync2_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // ****************************************
   // register file
   // ****************************************
   logic [7:0]  fsel_q, fsel_d;
   logic [7:0]  dir_q, dir_d;
   logic [7:0]  data_q, data_d;
   logic [7:0]  pull_q, pull_d;
   logic [31:0] prdata_d;
   logic        pslverr_d;
   logic        pready_d;
   logic        wr_en, rd_en, access, hit;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == pgp_pkg::ADDR_FUNC_SEL) || (a == pgp_pkg::ADDR_DIR) ||
                   (a == pgp_pkg::ADDR_DATA) || (a == pgp_pkg::ADDR_PULLUP);
   endfunction

   // one wait state: pready rises in the second access cycle
   assign access = psel && penable && !pready;
   assign hit    = addr_known(paddr);
   // write lands at the edge where pready is sampled high
   assign wr_en  = psel && penable && pready && pwrite && hit;
   assign rd_en  = access && !pwrite;

   always_comb begin
      fsel_d    = fsel_q;
      dir_d     = dir_q;
      data_d    = data_q;
      pull_d    = pull_q;
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      pready_d  = access;
      if (access && !hit) begin
         pslverr_d = 1'b1;
      end
      if (wr_en) begin
         case (paddr)
            pgp_pkg::ADDR_FUNC_SEL: fsel_d = pwdata[7:0] & pgp_pkg::FS_MASK;
            pgp_pkg::ADDR_DIR:      dir_d  = pwdata[7:0] & pgp_pkg::PORT_MASK;
            pgp_pkg::ADDR_DATA:     data_d = pwdata[7:0] & pgp_pkg::PORT_MASK;
            pgp_pkg::ADDR_PULLUP:   pull_d = pwdata[7:0] & pgp_pkg::PORT_MASK;
            default:                fsel_d = fsel_q;
         endcase
      end
      if (rd_en && hit) begin
         case (paddr)
            pgp_pkg::ADDR_FUNC_SEL: prdata_d = {24'h000000, fsel_q};
            // direction is write-only
            pgp_pkg::ADDR_DIR:      prdata_d = 32'h0000_0000;
            pgp_pkg::ADDR_DATA:     prdata_d = {24'h000000,
               ((dir_q & data_q) | (~dir_q & sync2_q & pgp_pkg::PORT_MASK))
               | pgp_pkg::RSVD_ONE};
            pgp_pkg::ADDR_PULLUP:   prdata_d = {24'h000000, pull_q | pgp_pkg::RSVD_ONE};
            default:                prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel_q  <= pgp_pkg::FS_RESET;
         dir_q   <= pgp_pkg::DIR_RESET;
         data_q  <= pgp_pkg::DATA_RESET;
         pull_q  <= pgp_pkg::PULLUP_RESET;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         fsel_q  <= fsel_d;
         dir_q   <= dir_d;
         data_q  <= data_d;
         pull_q  <= pull_d;
         prdata  <= prdata_d;
         pslverr <= pslverr_d;
         pready  <= pready_d;
      end
   end

   // ****************************************
   // pin control
   // ****************************************
   logic [7:0] periph_sel;
   logic [7:0] oe_d, out_d, pull_en_d;
   logic       ext_interrupt_3_input_d, trig_d, ext_interrupt_0_input_d, tx2_d, tx_d;

   always_comb begin
      periph_sel = 8'h00;
      // pin 7 to interrupt and timer
      periph_sel[7] = fsel_d[pgp_pkg::FS_PIN7_BIT];
      periph_sel[4] = fsel_d[pgp_pkg::FS_PIN4_BIT];
      oe_d  = dir_d & ~periph_sel & pgp_pkg::PORT_MASK;
      out_d = data_d & oe_d;
      pull_en_d = pull_d & ~dir_d & ~periph_sel & pgp_pkg::PORT_MASK;
      ext_interrupt_3_input_d = periph_sel[7] ? sync2_q[7] : 1'b1;
      trig_d = periph_sel[7] ? sync2_q[7] : 1'b1;
      ext_interrupt_0_input_d = periph_sel[4] ? sync2_q[4] : 1'b1;
      tx2_d = fsel_d[pgp_pkg::FS_TX2_BIT];
      tx_d  = fsel_d[pgp_pkg::FS_TX_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_oe                  <= 8'h00;
         pin_out                 <= 8'h00;
         pin_pullup              <= 8'h00;
         ext_interrupt_3_input   <= 1'b1;
         timer_trigger_input     <= 1'b1;
         ext_interrupt_0_input   <= 1'b1;
         second_serial_tx_select <= 1'b0;
         serial_tx_select        <= 1'b0;
      end else begin
         pin_oe                  <= oe_d;
         pin_out                 <= out_d;
         pin_pullup              <= pull_en_d;
         ext_interrupt_3_input   <= ext_interrupt_3_input_d;
         timer_trigger_input     <= trig_d;
         ext_interrupt_0_input   <= ext_interrupt_0_input_d;
         second_serial_tx_select <= tx2_d;
         serial_tx_select        <= tx_d;
      end
   end

endmodule // pgp_port1

// File: test/pgp_port1_properties.sv
module pgp_port1_properties (
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [7:0]  pin_out, pin_oe, pin_pullup,
   input wire logic        ext_interrupt_3_input, timer_trigger_input, ext_interrupt_0_input
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_done; psel && penable && pready && !pslverr; endsequence
   property p_rst_in; $rose(presetn) |-> pin_oe == 8'h00; endproperty
   property p_trg; ext_interrupt_3_input == timer_trigger_input; endproperty
   property p_int3; !ext_interrupt_3_input |-> !pin_oe[7]; endproperty
   property p_int0; !ext_interrupt_0_input |-> !pin_oe[4]; endproperty
   property p_rsv; s_done ##0 (!pwrite && paddr == pgp_pkg::ADDR_FUNC_SEL)
      |-> prdata[6:5] == 2'h0 && !prdata[0]; endproperty
   property p_one; s_done ##0 (!pwrite && paddr[3]) |-> prdata[3]; endproperty
   property p_dir; s_done ##0 (pwrite && paddr == pgp_pkg::ADDR_DIR)
      |=> (pin_oe & 8'h6F) == ($past(pwdata[7:0]) & 8'h67); endproperty
   property p_out; s_done ##0 (pwrite && paddr == pgp_pkg::ADDR_DATA)
      |=> (pin_out & pin_oe) == ($past(pwdata[7:0]) & pin_oe); endproperty
   property p_pu; (pin_pullup & pin_oe) == 8'h00; endproperty
   a_rst_in: assert property (p_rst_in) else $error("pin driven after reset");
   a_trg: assert property (p_trg) else $error("trigger differs from interrupt 3");
   a_int3: assert property (p_int3) else $error("pin 7 driven while routed");
   a_int0: assert property (p_int0) else $error("pin 4 driven while routed");
   a_rsv: assert property (p_rsv) else $error("reserved select bits not zero");
   a_one: assert property (p_one) else $error("reserved bit 3 not one");
   a_dir: assert property (p_dir) else $error("direction write not applied");
   a_out: assert property (p_out) else $error("data write not driven");
   a_pu: assert property (p_pu) else $error("pull-up on output pin");
endmodule // pgp_port1_properties
bind pgp_port1 pgp_port1_properties i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .pwdata, .prdata, .pin_out, .pin_oe, .pin_pullup,
   .ext_interrupt_3_input, .timer_trigger_input, .ext_interrupt_0_input);

// File: test/pgp_pins_model.sv
module pgp_pins_model (
   input wire logic       pclk,
   input wire logic [7:0] pin_out, pin_oe, pin_pullup, ext_v, ext_en,
   output logic     [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic flip_q = 1'h0;
   always @(posedge pclk) flip_q <= ~flip_q;
   // driven pin wins, then far side, then pull-up, else floating
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_v[i] : pin_pullup[i] | flip_q;
      end
   end
endmodule // pgp_pins_model

// File: test/tb_top.sv
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic        pready, pslverr, err_q, serial_tx_select, second_serial_tx_select;
   logic        ext_interrupt_3_input, timer_trigger_input, ext_interrupt_0_input;
   logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_v = 8'h5A, ext_en = 8'hFF;
   int          miscompares = 0, num_checks = 0;
   always #10 pclk = ~pclk;
   pgp_port1 i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .ext_interrupt_3_input,
      .timer_trigger_input, .ext_interrupt_0_input, .second_serial_tx_select,
      .serial_tx_select);
   pgp_pins_model i_pins (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_v, .ext_en, .pin_in);
   // ****************************************
   // apb master tasks
   // ****************************************
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'h1, a, {24'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      xfer(1'h0, a, 32'h0);
      `CHK("rdata", {24'h0, e}, rd_q)
      `CHK("slverr", a > 12'h00C, err_q)
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100us;
      miscompares++;
      complete_run;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      `CHK("oe", 8'h00, pin_oe)
      rd(pgp_pkg::ADDR_FUNC_SEL, 8'h00);
      rd(pgp_pkg::ADDR_DATA, 8'h5A);
      rd(pgp_pkg::ADDR_PULLUP, 8'h08);
      $display("test reset done");
      wr(pgp_pkg::ADDR_FUNC_SEL, 8'hFB);
      wr(pgp_pkg::ADDR_DIR, 8'hFF);
      wr(pgp_pkg::ADDR_PULLUP, 8'hFF);
      rd(pgp_pkg::ADDR_FUNC_SEL, 8'h9A);
      `CHK("oe", 8'h67, pin_oe)
      `CHK("pullup", 8'h00, pin_pullup)
      `CHK("ext_interrupt_3_input", 1'h0, ext_interrupt_3_input)
      `CHK("trig", 1'h0, timer_trigger_input)
      `CHK("ext_interrupt_0_input", 1'h1, ext_interrupt_0_input)
      `CHK("tx2", 1'h1, second_serial_tx_select)
      `CHK("tx", 1'h1, serial_tx_select)
      $display("test select done");
      wr(pgp_pkg::ADDR_FUNC_SEL, 8'h00);
      wr(pgp_pkg::ADDR_DIR, 8'h0F);
      ext_en <= 8'hF8;
      wr(pgp_pkg::ADDR_DATA, 8'hA5);
      `CHK("oe", 8'h07, pin_oe)
      `CHK("out", 8'h05, pin_out & pin_oe)
      `CHK("pullup", 8'hF0, pin_pullup)
      rd(pgp_pkg::ADDR_DATA, 8'h5D);
      rd(pgp_pkg::ADDR_PULLUP, 8'hFF);
      rd(pgp_pkg::ADDR_DIR, 8'h00);
      rd(12'h010, 8'h00);
      $display("test data done");
      complete_run;
   end
endmodule // tb_top
